// File: hw/smr_top.sv
// Stop-mode wake-up, recovery and reset-cause logic with APB registers.
`timescale 1ns/10ps
module smr_top
	import smr_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core interface
	input wire logic stop_req,
	input wire logic irq_enable,
	output logic core_halted,
	output logic core_run,
	output logic pc_load,
	output logic [15:0] pc_value,
	output smr_post_t post_irq,
	// Program memory
	output logic [15:0] pmem_addr,
	output logic pmem_rd,
	input wire logic [7:0] pmem_rdata,
	// Wake sources
	input wire smr_wake_t wake_src,
	input wire logic [SMR_PORTS*SMR_PINS-1:0] port_pins,
	input wire logic ext_reset_n,
	input wire logic debug_pin,
	// System reset request and interrupt
	output logic sys_reset_req,
	output logic irq
);

	typedef enum logic [2:0] {
		SMR_S_BOOT,
		SMR_S_FETCH,
		SMR_S_LOAD,
		SMR_S_POST,
		SMR_S_RUN,
		SMR_S_STOP
	} smr_state_t;

	smr_state_t st_q;
	smr_src_t src_q;
	logic [7:0] ctrl_q;
	logic [7:0] cause_q;
	logic [7:0] pwe_q [SMR_PORTS];
	logic [SMR_PORTS*SMR_PINS-1:0] pwe_flat;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [1:0] irq_set;
	smr_post_t pend_q;
	logic pin_wake;
	logic fetch_start;
	logic fetch_done;
	logic [15:0] vector;
	logic in_stop;
	logic wdt_wake;
	logic tmr_wake;
	logic cmp_wake;
	logic stop_wake;
	logic sys_wake;
	logic wr_acc;
	logic rd_setup;
	logic rd_acc;
	logic hit;
	logic pwe_hit;
	logic [2:0] pwe_idx;

	assign in_stop = (st_q == SMR_S_STOP);

	// Wake qualification while halted.
	assign wdt_wake = in_stop & wake_src.wdt_timeout;
	assign tmr_wake = in_stop & wake_src.tmr_irq & ctrl_q[SMR_CTRL_TMR_STOP];
	assign cmp_wake = in_stop & wake_src.cmp_irq & ctrl_q[SMR_CTRL_CMP_STOP];
	assign sys_wake = in_stop & (~ext_reset_n | ~debug_pin);
	assign stop_wake = wdt_wake | tmr_wake | cmp_wake | pin_wake;

	genvar p;
	generate
		for (p = 0; p < SMR_PORTS; p++) begin : g_port
			assign pwe_flat[p*SMR_PINS +: SMR_PINS] = pwe_q[p];
		end
	endgenerate

	smr_pin_wake u_pin_wake (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(port_pins),
		.pin_en(pwe_flat),
		.armed(in_stop),
		.wake(pin_wake)
	);

	assign fetch_start = (st_q == SMR_S_BOOT);

	smr_vec_fetch u_vec_fetch (
		.pclk(pclk),
		.presetn(presetn),
		.start(fetch_start),
		.done(fetch_done),
		.vector(vector),
		.pmem_addr(pmem_addr),
		.pmem_rd(pmem_rd),
		.pmem_rdata(pmem_rdata)
	);

	// Sequencer. The core restarts only after the vector is loaded.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= SMR_S_BOOT;
		end else begin
			unique case (st_q)
				SMR_S_BOOT: st_q <= SMR_S_FETCH;
				SMR_S_FETCH: if (fetch_done) st_q <= SMR_S_LOAD;
				SMR_S_LOAD: st_q <= SMR_S_POST;
				SMR_S_POST: st_q <= SMR_S_RUN;
				SMR_S_RUN: if (stop_req) st_q <= SMR_S_STOP;
				SMR_S_STOP: if (sys_wake || stop_wake) st_q <= SMR_S_BOOT;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= SMR_SRC_NONE;
		end else if (in_stop) begin
			if (sys_wake) begin
				src_q <= SMR_SRC_SYSRST;
			end else if (stop_wake) begin
				src_q <= SMR_SRC_STOP;
			end
		end else if (st_q == SMR_S_RUN) begin
			src_q <= SMR_SRC_NONE;
		end
	end

	// Reset cause record. A system reset wins over a simultaneous wake.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_q <= SMR_CAUSE_RESET;
		end else if (sys_wake) begin
			cause_q <= 8'h00;
			cause_q[SMR_CAUSE_PIN] <= 1'b1;
		end else if (stop_wake) begin
			cause_q <= 8'h00;
			cause_q[SMR_CAUSE_STOP] <= 1'b1;
			cause_q[SMR_CAUSE_WDT] <= wdt_wake;
		end
	end

	// Interrupts held back until the restart sequence has finished.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= '0;
		end else if (sys_wake) begin
			pend_q <= '0;
		end else if (stop_wake) begin
			pend_q.wdt <= wdt_wake & ctrl_q[SMR_CTRL_WDT_INT];
			pend_q.tmr <= tmr_wake;
			pend_q.cmp <= cmp_wake;
		end else if (st_q == SMR_S_POST) begin
			pend_q <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_irq <= '0;
		end else if (st_q == SMR_S_POST && irq_enable) begin
			post_irq <= pend_q;
		end else begin
			post_irq <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_load <= 1'b0;
			pc_value <= 16'h0000;
		end else begin
			pc_load <= (st_q == SMR_S_LOAD);
			if (st_q == SMR_S_LOAD) pc_value <= vector;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_reset_req <= 1'b0;
		end else begin
			sys_reset_req <= sys_wake;
		end
	end

	assign core_halted = in_stop;
	assign core_run = (st_q == SMR_S_RUN);

	// APB decode.
	assign wr_acc = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pwe_hit = (paddr >= SMR_ADDR_PWE_BASE) && (paddr < SMR_ADDR_IRQ_STAT) && (paddr[1:0] == 2'h0);
	assign pwe_idx = 3'((paddr - SMR_ADDR_PWE_BASE) >> 2);
	assign hit = pwe_hit || paddr == SMR_ADDR_CTRL || paddr == SMR_ADDR_IRQ_STAT
		|| paddr == SMR_ADDR_IRQ_MASK || paddr == SMR_ADDR_STATE || paddr == SMR_ADDR_CAUSE;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= SMR_CTRL_RESET;
			irq_mask_q <= SMR_IRQ_RESET;
		end else if (wr_acc) begin
			if (paddr == SMR_ADDR_CTRL) ctrl_q <= {5'h00, pwdata[2:0]};
			if (paddr == SMR_ADDR_IRQ_MASK) irq_mask_q <= pwdata[1:0];
		end
	end

	generate
		for (p = 0; p < SMR_PORTS; p++) begin : g_pwe
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pwe_q[p] <= SMR_PWE_RESET;
				end else if (wr_acc && pwe_hit && pwe_idx == 3'(p)) begin
					pwe_q[p] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	// Sticky events; a new event in the clearing read's cycle survives.
	assign irq_set = {sys_wake, stop_wake & ~sys_wake};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= SMR_IRQ_RESET;
		end else if (rd_acc && paddr == SMR_ADDR_IRQ_STAT) begin
			irq_stat_q <= irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// Read data is captured in the setup cycle and held through access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			if (pwe_hit) begin
				prdata <= {24'h000000, pwe_q[pwe_idx]};
			end else if (paddr == SMR_ADDR_CTRL) begin
				prdata <= {24'h000000, ctrl_q};
			end else if (paddr == SMR_ADDR_IRQ_STAT) begin
				prdata <= {30'h00000000, irq_stat_q | irq_set};
			end else if (paddr == SMR_ADDR_IRQ_MASK) begin
				prdata <= {30'h00000000, irq_mask_q};
			end else if (paddr == SMR_ADDR_STATE) begin
				prdata <= {29'h0000000, 2'(src_q), core_halted};
			end else if (paddr == SMR_ADDR_CAUSE) begin
				prdata <= {24'h000000, cause_q};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

endmodule

// File: hw/smr_pkg.sv
// Constants and types shared by the stop-mode recovery block.
package smr_pkg;

	localparam int SMR_PORTS = 5;
	localparam int SMR_PINS = 8;

	// APB byte addresses.
	localparam logic [11:0] SMR_ADDR_CTRL = 12'h000;
	localparam logic [11:0] SMR_ADDR_PWE_BASE = 12'h004;
	localparam logic [11:0] SMR_ADDR_IRQ_STAT = 12'h018;
	localparam logic [11:0] SMR_ADDR_IRQ_MASK = 12'h01c;
	localparam logic [11:0] SMR_ADDR_STATE = 12'h020;
	localparam logic [11:0] SMR_ADDR_CAUSE = 12'hff0;

	// Control register fields.
	localparam int SMR_CTRL_WDT_INT = 0;
	localparam int SMR_CTRL_TMR_STOP = 1;
	localparam int SMR_CTRL_CMP_STOP = 2;
	localparam logic [7:0] SMR_CTRL_RESET = 8'h00;

	// Reset cause status fields.
	localparam int SMR_CAUSE_STOP = 4;
	localparam int SMR_CAUSE_WDT = 5;
	localparam int SMR_CAUSE_PIN = 6;
	localparam int SMR_CAUSE_POR = 7;
	localparam logic [7:0] SMR_CAUSE_RESET = 8'h80;

	// Interrupt status fields.
	localparam int SMR_IRQ_RECOVERED = 0;
	localparam int SMR_IRQ_SYSRESET = 1;
	localparam logic [1:0] SMR_IRQ_RESET = 2'h0;

	localparam logic [7:0] SMR_PWE_RESET = 8'h00;

	// Restart vector location in program memory.
	localparam logic [15:0] SMR_VEC_HI_ADDR = 16'h0002;
	localparam logic [15:0] SMR_VEC_LO_ADDR = 16'h0003;

	typedef enum logic [1:0] {
		SMR_SRC_NONE,
		SMR_SRC_STOP,
		SMR_SRC_SYSRST
	} smr_src_t;

	// Wake sources offered by the peripherals.
	typedef struct packed {
		logic wdt_timeout;
		logic tmr_irq;
		logic cmp_irq;
	} smr_wake_t;

	// Interrupt requests posted to the core after recovery.
	typedef struct packed {
		logic wdt;
		logic tmr;
		logic cmp;
	} smr_post_t;

endpackage

// File: hw/smr_pin_wake.sv
// Per-pin change detector gated by the port wake-source enables.
`timescale 1ns/10ps
module smr_pin_wake
	import smr_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins and enables
	input wire logic [SMR_PORTS*SMR_PINS-1:0] pin_in,
	input wire logic [SMR_PORTS*SMR_PINS-1:0] pin_en,
	input wire logic armed,
	// Result
	output logic wake
);

	logic [SMR_PORTS*SMR_PINS-1:0] prev_q;
	logic [SMR_PORTS*SMR_PINS-1:0] hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= pin_in;
		end
	end

	genvar i;
	generate
		for (i = 0; i < SMR_PORTS*SMR_PINS; i++) begin : g_pin
			// A pin without its enable never wakes the device.
			assign hit[i] = pin_en[i] & (pin_in[i] ^ prev_q[i]);
		end
	endgenerate

	assign wake = armed & (|hit);

endmodule

// File: hw/smr_vec_fetch.sv
// Two-byte restart vector read from program memory.
`timescale 1ns/10ps
module smr_vec_fetch
	import smr_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic start,
	output logic done,
	output logic [15:0] vector,
	// Program memory, data one cycle after the read strobe
	output logic [15:0] pmem_addr,
	output logic pmem_rd,
	input wire logic [7:0] pmem_rdata
);

	typedef enum logic [1:0] {
		SMR_F_IDLE,
		SMR_F_HI,
		SMR_F_LO,
		SMR_F_END
	} smr_fetch_t;

	smr_fetch_t st_q;
	logic [7:0] hi_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= SMR_F_IDLE;
		end else begin
			unique case (st_q)
				SMR_F_IDLE: if (start) st_q <= SMR_F_HI;
				SMR_F_HI: st_q <= SMR_F_LO;
				SMR_F_LO: st_q <= SMR_F_END;
				SMR_F_END: st_q <= SMR_F_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= 8'h00;
			vector <= 16'h0000;
		end else begin
			if (st_q == SMR_F_LO) hi_q <= pmem_rdata;
			if (st_q == SMR_F_END) vector <= {hi_q, pmem_rdata};
		end
	end

	assign pmem_rd = (st_q == SMR_F_HI) || (st_q == SMR_F_LO);
	assign pmem_addr = (st_q == SMR_F_LO) ? SMR_VEC_LO_ADDR : SMR_VEC_HI_ADDR;
	assign done = (st_q == SMR_F_END);

endmodule

// File: verification/smr_core_model.sv
// Program memory model that answers the restart vector fetch.
`timescale 1ns/10ps
module smr_core_model #(
	parameter logic [15:0] VEC = 16'h4a5c
) (
	// Clock
	input wire logic pclk,
	// Program memory
	input wire logic [15:0] pmem_addr,
	input wire logic pmem_rd,
	output logic [7:0] pmem_rdata
);
	initial pmem_rdata = 8'h00;
	// Between reads the data bus keeps changing, so a late sample cannot pass.
	always @(posedge pclk) begin
		if (pmem_rd) begin
			pmem_rdata <= (pmem_addr == 16'h0002) ? VEC[15:8] : (pmem_addr == 16'h0003) ? VEC[7:0] : 8'h00;
		end else begin
			pmem_rdata <= ~pmem_rdata;
		end
	end
endmodule

// File: verification/smr_chk.sv
// Concurrent checks on the stop-mode recovery block ports.
`timescale 1ns/10ps
module smr_chk
	import smr_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Observed ports
	input wire logic irq_enable,
	input wire logic core_halted,
	input wire logic core_run,
	input wire logic pc_load,
	input wire smr_post_t post_irq,
	input wire logic [15:0] pmem_addr,
	input wire logic pmem_rd,
	input wire smr_wake_t wake_src,
	input wire logic [SMR_PORTS*SMR_PINS-1:0] port_pins,
	input wire logic ext_reset_n,
	input wire logic debug_pin,
	input wire logic sys_reset_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_vec_order: assert property (pmem_rd && pmem_addr == 16'h0002 |=> pmem_rd && pmem_addr == 16'h0003)
		else $error("vector fetch order wrong");
	chk_run_after_load: assert property (pc_load |-> !core_run ##[1:3] core_run)
		else $error("core not released after load");
	chk_post_after_load: assert property (post_irq != 3'h0 |-> $past(pc_load))
		else $error("interrupt posted before recovery");
	chk_post_enabled: assert property (post_irq != 3'h0 |-> $past(irq_enable))
		else $error("interrupt posted while disabled");
	chk_wdt_wake: assert property (core_halted && wake_src.wdt_timeout |=> !core_halted)
		else $error("watchdog did not wake");
	chk_ext_reset: assert property (core_halted && !ext_reset_n |-> ##[1:2] sys_reset_req)
		else $error("reset pin gave no system reset");
	chk_debug_reset: assert property (core_halted && !debug_pin |-> ##[1:2] sys_reset_req)
		else $error("debug pin gave no system reset");
	chk_halt_quiet: assert property (core_halted && wake_src == 3'h0 && ext_reset_n && debug_pin
		&& $stable(port_pins) |=> core_halted)
		else $error("woke without an event");
	chk_halt_no_run: assert property (core_halted |-> !core_run)
		else $error("core runs while halted");
endmodule

bind smr_top smr_chk smr_chk_i (.*);

// File: verification/tb_top.sv
// Self-checking bench for the stop-mode recovery block.
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top
	import smr_pkg::*;
;
	localparam logic [15:0] VEC = 16'h4a5c;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic stop_req = 1'h0, irq_enable = 1'h1, ext_reset_n = 1'h1, debug_pin = 1'h1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, slv, core_halted, core_run, pc_load, pmem_rd, sys_reset_req, irq, srq_seen;
	logic [15:0] pc_value, pmem_addr;
	logic [7:0] pmem_rdata;
	logic [SMR_PORTS*SMR_PINS-1:0] port_pins = 40'h0;
	smr_post_t post_irq, post_seen;
	smr_wake_t wake_src = 3'h0;
	int err_total = 0, checked = 0, cyc = 0;
	logic [2:0] ctl [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0, 3'h0, 3'h0, 3'h1};
	logic [2:0] wk [8] = '{3'h4, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h4};
	logic [2:0] pst [8] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
	logic [1:0] rn [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
	logic [31:0] cs [8] = '{32'h30, 32'h30, 32'h10, 32'h10, 32'h10, 32'h40, 32'h40, 32'h30};

	smr_top smr_top_i (.*);
	smr_core_model #(.VEC(VEC)) smr_core_model_i (.*);

	always #12.5 pclk = ~pclk;

	always @(negedge pclk) begin
		post_seen = post_seen | post_irq;
		srq_seen = srq_seen | sys_reset_req;
	end

	task automatic print_verdict;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			print_verdict;
		end
	end

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		slv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic sleep;
		post_seen = 3'h0;
		srq_seen = 1'h0;
		stop_req <= 1'h1;
		@(posedge pclk);
		stop_req <= 1'h0;
		repeat (20) if (core_halted !== 1'h1) @(posedge pclk);
	endtask

	task automatic kick(input logic [2:0] s, input logic [39:0] p, input logic [1:0] r);
		wake_src <= s;
		port_pins <= port_pins ^ p;
		ext_reset_n <= !r[1];
		debug_pin <= !r[0];
		@(posedge pclk);
		wake_src <= 3'h0;
		ext_reset_n <= 1'h1;
		debug_pin <= 1'h1;
		repeat (30) if (core_run !== 1'h1) @(posedge pclk);
	endtask

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		repeat (30) if (core_run !== 1'h1) @(posedge pclk);
		`CHK("boot_vector", VEC, pc_value)
		apb(1'h1, SMR_ADDR_CAUSE, 32'h0);
		apb(1'h0, SMR_ADDR_CAUSE, 32'h0);
		`CHK("cause_por", 32'h80, rd)
		apb(1'h0, 12'h100, 32'h0);
		`CHK("unmapped", 1'h1, slv)
		apb(1'h1, SMR_ADDR_PWE_BASE + 12'h8, 32'h8);
		apb(1'h0, SMR_ADDR_PWE_BASE + 12'h8, 32'h0);
		`CHK("port_c_enable", 32'h8, rd)
		for (int i = 0; i < 8; i++) begin
			apb(1'h1, SMR_ADDR_CTRL, {29'h0, ctl[i]});
			apb(1'h1, SMR_ADDR_IRQ_MASK, {30'h0, i == 5, i == 4});
			irq_enable <= (i != 7);
			sleep;
			if (i == 4) begin
				kick(3'h3, 40'h40000, 2'h0);
				`CHK("ignored", 1'h1, core_halted)
				apb(1'h0, SMR_ADDR_STATE, 32'h0);
				`CHK("state_halted", 32'h1, rd)
			end
			kick(wk[i], (i == 4) ? 40'h80000 : 40'h0, rn[i]);
			`CHK("pc_value", VEC, pc_value)
			`CHK("post_irq", pst[i], post_seen)
			`CHK("sys_reset", rn[i] != 2'h0, srq_seen)
			apb(1'h0, SMR_ADDR_CAUSE, 32'h0);
			`CHK("cause", cs[i], rd)
			`CHK("irq", i == 4 || i == 5, irq)
			apb(1'h0, SMR_ADDR_IRQ_STAT, 32'h0);
			`CHK("irq_status", (rn[i] != 2'h0) ? 32'h2 : 32'h1, rd)
			`CHK("irq_cleared", 1'h0, irq)
		end
		print_verdict;
	end
endmodule
